/* File: rtl/qfd_pkg.sv */
// constants and types for the quad i/o flash command decoder
package qfd_pkg;
  // instruction codes
  localparam logic [7:0] CODE_IDENT = 8'hAF;
  localparam logic [7:0] CODE_READ_A = 8'h0B;
  localparam logic [7:0] CODE_READ_B = 8'h6B;
  localparam logic [7:0] CODE_READ_C = 8'hEB;
  localparam logic [7:0] CODE_OTP_RD = 8'h4B;
  localparam logic [7:0] CODE_WR_ENABLE = 8'h06;
  localparam logic [7:0] CODE_WR_DISABLE = 8'h04;
  localparam logic [7:0] CODE_PROG_A = 8'h02;
  localparam logic [7:0] CODE_PROG_B = 8'h12;
  localparam logic [7:0] CODE_PROG_C = 8'h32;
  localparam logic [7:0] CODE_OTP_PR = 8'h42;
  localparam logic [7:0] CODE_ERASE = 8'h20;
  localparam logic [7:0] CODE_RDSR = 8'h05;
  localparam logic [7:0] CODE_RFSR = 8'h70;
  // identification values: arbitrary, not any real maker or part
  localparam logic [7:0] ID_MAKER = 8'h5A;
  localparam logic [15:0] ID_PART = 16'hC3E1;
  localparam logic [6:0] ID_BYTES = 7'h03;
  // phase lengths and limits
  localparam logic [3:0] CMD_LAST_NIB = 4'h1;
  localparam logic [3:0] ADDR_LAST_NIB = 4'h5;
  localparam logic [3:0] OTP_DUMMY = 4'h8;
  localparam logic [3:0] DUMMY_DEFAULT = 4'hA;
  localparam logic [6:0] OTP_BYTES = 7'h40;
  localparam int FIFO_DEPTH = 4;
  // boot region: 8 sectors of 64 KiB, 16 subsectors of 4 KiB each
  localparam logic BOOT_AT_TOP = 1'b0;
  localparam int BOOT_MSB = 19;
  localparam int SUBSECTOR_LSB = 12;
  // reset values
  localparam logic LATCH_RESET = 1'b0;
  localparam logic [3:0] OE_N_RESET = 4'hF;

  typedef enum logic [3:0] {
    OP_NONE, OP_IDENT, OP_READ, OP_OTP_RD, OP_WR_ENABLE, OP_WR_DISABLE,
    OP_PROG, OP_OTP_PR, OP_ERASE, OP_RDSR, OP_RFSR
  } qfd_op_type;

  typedef struct packed {
    logic otp;
    logic [23:0] addr;
    logic [7:0] data;
  } qfd_prog_type;
endpackage

/* File: rtl/qfd_fifo.sv */
// small fifo with registered read side
`timescale 1ns/1ps
module qfd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic next_out_valid;
  logic wr, rd;

  always_comb begin
    in_ready = (count != FULL);
    wr = in_valid && in_ready;
    rd = (count != '0) && (!out_valid || out_ready);
    next_wr_ptr = wr ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = rd ? rd_ptr + AW'(1) : rd_ptr;
    next_count = count + (AW+1)'(wr) - (AW+1)'(rd);
    next_out_valid = rd ? 1'b1 : (out_ready ? 1'b0 : out_valid);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_valid <= next_out_valid;
    end
  end

  // storage carries no reset; only valid words are ever read
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wr_ptr] <= in_data;
    end
    if (!rst_n) begin
      out_data <= '0;
    end else if (rd) begin
      out_data <= mem[rd_ptr];
    end
  end
endmodule

/* File: rtl/qfd_decoder.sv */
// quad i/o serial flash instruction decoder and sequencer
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - ident read returns maker byte, two part bytes
// - no unique identifier bytes after three
// - ident read ignored while program/erase busy
// - ident nibbles driven on falling clock edge
// - chip select high stops data drive at once
// - deselect returns to standby awaiting new instruction
// - codes 0B, 6B, EB all fast read
// - fast read quad address and data, endless
// - otp read from 64-byte area, quad
// - otp read uses eight full dummy clocks
// - write enable sets the latch
// - write disable clears the latch
// - program and erase need latch set first
// - codes 02, 12, 32 all page program
// - page program quad address and input data
// - otp program at most 64 bytes, only clears
// - eight boot sectors of sixteen 4K subsectors
// - subsector erase sets all bits to one
// - erase sends code and address, no data
// - fast read dummy count configurable, default ten
// - status polling answered while busy
module qfd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_n,
  // configuration and array state
  input wire logic busy,
  input wire logic [3:0] dummy_cycles,
  output logic write_enable_latch,
  // array read port
  output logic rd_req,
  output logic [23:0] rd_addr,
  output logic rd_otp,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // program data stream
  output logic prog_valid,
  output qfd_pkg::qfd_prog_type prog_word,
  input wire logic prog_ready,
  output logic prog_overrun,
  // erase request
  output logic erase_req,
  output logic [11:0] erase_subsector
);
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_OUT, ST_IN, ST_SKIP} qfd_state_type;

  function automatic qfd_pkg::qfd_op_type qfd_decode(input logic [7:0] c);
    case (c)
      qfd_pkg::CODE_IDENT: qfd_decode = qfd_pkg::OP_IDENT;
      qfd_pkg::CODE_READ_A, qfd_pkg::CODE_READ_B, qfd_pkg::CODE_READ_C: begin
        qfd_decode = qfd_pkg::OP_READ;
      end
      qfd_pkg::CODE_OTP_RD: qfd_decode = qfd_pkg::OP_OTP_RD;
      qfd_pkg::CODE_WR_ENABLE: qfd_decode = qfd_pkg::OP_WR_ENABLE;
      qfd_pkg::CODE_WR_DISABLE: qfd_decode = qfd_pkg::OP_WR_DISABLE;
      qfd_pkg::CODE_PROG_A, qfd_pkg::CODE_PROG_B, qfd_pkg::CODE_PROG_C: begin
        qfd_decode = qfd_pkg::OP_PROG;
      end
      qfd_pkg::CODE_OTP_PR: qfd_decode = qfd_pkg::OP_OTP_PR;
      qfd_pkg::CODE_ERASE: qfd_decode = qfd_pkg::OP_ERASE;
      qfd_pkg::CODE_RDSR: qfd_decode = qfd_pkg::OP_RDSR;
      qfd_pkg::CODE_RFSR: qfd_decode = qfd_pkg::OP_RFSR;
      default: qfd_decode = qfd_pkg::OP_NONE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; edges are read only from the second stage onward
  logic cs_meta, cs_s, cs_d, sck_meta, sck_s, sck_d;
  logic [3:0] dq_meta, dq_s;
  logic sck_rise, sck_fall, cs_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_meta <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      sck_meta <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      dq_meta <= '0;
      dq_s <= '0;
    end else begin
      cs_meta <= cs_n;
      cs_s <= cs_meta;
      cs_d <= cs_s;
      sck_meta <= sclk;
      sck_s <= sck_meta;
      sck_d <= sck_s;
      dq_meta <= dq_i;
      dq_s <= dq_meta;
    end
  end

  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;
  assign cs_rise = cs_s && !cs_d;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  qfd_state_type st, next_st;
  qfd_pkg::qfd_op_type op, next_op, dop;
  logic [3:0] cnt, next_cnt, dummy_tgt;
  logic [23:0] sr, next_sr, addr, next_addr, step_addr;
  logic [6:0] byte_cnt, next_byte_cnt;
  logic [7:0] code, rd_byte, next_rd_byte, src, in_byte;
  logic phase, next_phase, addr_done, next_addr_done, in_boot;
  logic [3:0] next_dq_o, next_oe_n;
  logic next_write_enable_latch, next_rd_req, next_rd_otp, next_overrun, next_erase_req;
  logic [23:0] next_rd_addr;
  logic [11:0] next_erase_subsector;
  logic push, fifo_ready;
  qfd_pkg::qfd_prog_type push_word;

  always_comb begin
    next_st = st;
    next_op = op;
    next_cnt = cnt;
    next_sr = sr;
    next_addr = addr;
    next_addr_done = addr_done;
    next_byte_cnt = byte_cnt;
    next_phase = phase;
    next_dq_o = dq_o;
    next_oe_n = dq_oe_n;
    next_write_enable_latch = write_enable_latch;
    next_rd_req = 1'b0;
    next_rd_addr = rd_addr;
    next_rd_otp = rd_otp;
    next_rd_byte = rd_valid ? rd_data : rd_byte;
    next_overrun = prog_overrun;
    next_erase_req = 1'b0;
    next_erase_subsector = erase_subsector;
    push = 1'b0;
    code = {sr[3:0], dq_s};
    dop = qfd_decode(code);
    in_byte = {sr[3:0], dq_s};
    dummy_tgt = (op == qfd_pkg::OP_OTP_RD) ? qfd_pkg::OTP_DUMMY : dummy_cycles;
    in_boot = qfd_pkg::BOOT_AT_TOP ? (&addr[23:qfd_pkg::BOOT_MSB])
                                   : !(|addr[23:qfd_pkg::BOOT_MSB]);
    // otp addresses wrap inside the 64-byte area, pages inside 256 bytes
    if (op == qfd_pkg::OP_OTP_RD || op == qfd_pkg::OP_OTP_PR) begin
      step_addr = {18'h00000, addr[5:0] + 6'h01};
    end else if (op == qfd_pkg::OP_PROG) begin
      step_addr = {addr[23:8], addr[7:0] + 8'h01};
    end else begin
      step_addr = addr + 24'h000001;
    end
    case (op)
      qfd_pkg::OP_IDENT: src = sr[23:16];
      qfd_pkg::OP_RDSR: src = {6'h00, write_enable_latch, busy};
      qfd_pkg::OP_RFSR: src = {!busy, 7'h00};
      default: src = rd_byte;
    endcase
    push_word.otp = (op == qfd_pkg::OP_OTP_PR);
    push_word.addr = addr;
    push_word.data = in_byte;

    if (cs_s) begin
      // deselect: standby, release pins, commit the finished instruction
      next_st = ST_CMD;
      next_cnt = '0;
      next_phase = 1'b0;
      next_byte_cnt = '0;
      next_addr_done = 1'b0;
      next_oe_n = 4'hF;
      next_op = qfd_pkg::OP_NONE;
      if (cs_rise) begin
        case (op)
          qfd_pkg::OP_WR_ENABLE: next_write_enable_latch = 1'b1;
          qfd_pkg::OP_WR_DISABLE: next_write_enable_latch = 1'b0;
          qfd_pkg::OP_ERASE: begin
            if (addr_done && in_boot) begin
              next_erase_req = 1'b1;
              next_erase_subsector = addr[23:qfd_pkg::SUBSECTOR_LSB];
            end
            next_write_enable_latch = 1'b0;
          end
          qfd_pkg::OP_PROG, qfd_pkg::OP_OTP_PR: next_write_enable_latch = 1'b0;
          default: next_write_enable_latch = write_enable_latch;
        endcase
      end
    end else begin
      case (st)
        ST_CMD: begin
          if (sck_rise) begin
            next_sr = {sr[19:0], dq_s};
            next_cnt = cnt + 4'h1;
            if (cnt == qfd_pkg::CMD_LAST_NIB) begin
              next_cnt = '0;
              next_st = ST_SKIP;
              next_op = qfd_pkg::OP_NONE;
              if (busy && dop != qfd_pkg::OP_RDSR && dop != qfd_pkg::OP_RFSR) begin
                next_st = ST_SKIP;
              end else if ((dop == qfd_pkg::OP_PROG || dop == qfd_pkg::OP_OTP_PR ||
                            dop == qfd_pkg::OP_ERASE) && !write_enable_latch) begin
                next_st = ST_SKIP;
              end else begin
                next_op = dop;
                case (dop)
                  qfd_pkg::OP_IDENT: begin
                    next_st = ST_OUT;
                    next_sr = {qfd_pkg::ID_MAKER, qfd_pkg::ID_PART};
                  end
                  qfd_pkg::OP_RDSR, qfd_pkg::OP_RFSR: next_st = ST_OUT;
                  qfd_pkg::OP_READ, qfd_pkg::OP_OTP_RD, qfd_pkg::OP_PROG,
                  qfd_pkg::OP_OTP_PR, qfd_pkg::OP_ERASE: next_st = ST_ADDR;
                  default: next_st = ST_SKIP;
                endcase
              end
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            next_addr = {addr[19:0], dq_s};
            next_cnt = cnt + 4'h1;
            if (cnt == qfd_pkg::ADDR_LAST_NIB) begin
              next_cnt = '0;
              case (op)
                qfd_pkg::OP_ERASE: begin
                  next_addr_done = 1'b1;
                  next_st = ST_SKIP;
                end
                qfd_pkg::OP_PROG, qfd_pkg::OP_OTP_PR: next_st = ST_IN;
                default: begin
                  if (op == qfd_pkg::OP_OTP_RD) begin
                    next_addr = {18'h00000, addr[1:0], dq_s};
                  end
                  next_rd_req = 1'b1;
                  next_rd_addr = next_addr;
                  next_rd_otp = (op == qfd_pkg::OP_OTP_RD);
                  next_st = (dummy_tgt == 4'h0) ? ST_OUT : ST_DUMMY;
                end
              endcase
            end
          end
        end
        ST_DUMMY: begin
          if (sck_rise) begin
            next_cnt = cnt + 4'h1;
            if (cnt == dummy_tgt - 4'h1) begin
              next_cnt = '0;
              next_st = ST_OUT;
            end
          end
        end
        ST_OUT: begin
          if (sck_fall) begin
            if (op == qfd_pkg::OP_IDENT && byte_cnt == qfd_pkg::ID_BYTES) begin
              next_oe_n = 4'hF;
              next_st = ST_SKIP;
            end else begin
              next_oe_n = 4'h0;
              next_dq_o = phase ? src[3:0] : src[7:4];
              next_phase = !phase;
              if (phase) begin
                next_byte_cnt = byte_cnt + 7'h01;
                if (op == qfd_pkg::OP_IDENT) begin
                  next_sr = {sr[15:0], 8'h00};
                end
                if (op == qfd_pkg::OP_READ || op == qfd_pkg::OP_OTP_RD) begin
                  next_addr = step_addr;
                  next_rd_addr = step_addr;
                  next_rd_req = 1'b1;
                end
              end
            end
          end
        end
        ST_IN: begin
          if (sck_rise) begin
            next_phase = !phase;
            next_sr = {sr[19:0], dq_s};
            if (phase) begin
              // past 64 otp bytes the data is dropped silently
              if (op != qfd_pkg::OP_OTP_PR || byte_cnt != qfd_pkg::OTP_BYTES) begin
                next_byte_cnt = byte_cnt + 7'h01;
                next_addr = step_addr;
                // the host cannot be stalled, so a full fifo loses the byte
                if (fifo_ready) begin
                  push = 1'b1;
                end else begin
                  next_overrun = 1'b1;
                end
              end
            end
          end
        end
        ST_SKIP: next_st = ST_SKIP;
        default: next_st = ST_CMD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= ST_CMD;
      op <= qfd_pkg::OP_NONE;
      cnt <= '0;
      sr <= '0;
      addr <= '0;
      addr_done <= 1'b0;
      byte_cnt <= '0;
      phase <= 1'b0;
      dq_o <= '0;
      dq_oe_n <= qfd_pkg::OE_N_RESET;
      write_enable_latch <= qfd_pkg::LATCH_RESET;
      rd_req <= 1'b0;
      rd_addr <= '0;
      rd_otp <= 1'b0;
      rd_byte <= '0;
      prog_overrun <= 1'b0;
      erase_req <= 1'b0;
      erase_subsector <= '0;
    end else begin
      st <= next_st;
      op <= next_op;
      cnt <= next_cnt;
      sr <= next_sr;
      addr <= next_addr;
      addr_done <= next_addr_done;
      byte_cnt <= next_byte_cnt;
      phase <= next_phase;
      dq_o <= next_dq_o;
      dq_oe_n <= next_oe_n;
      write_enable_latch <= next_write_enable_latch;
      rd_req <= next_rd_req;
      rd_addr <= next_rd_addr;
      rd_otp <= next_rd_otp;
      rd_byte <= next_rd_byte;
      prog_overrun <= next_overrun;
      erase_req <= next_erase_req;
      erase_subsector <= next_erase_subsector;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // program data buffer toward the array
  qfd_fifo #(
    .WIDTH($bits(qfd_pkg::qfd_prog_type)),
    .DEPTH(qfd_pkg::FIFO_DEPTH)
  ) qfd_fifo_inst (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_data(push_word),
    .in_ready(fifo_ready),
    .out_valid(prog_valid),
    .out_data(prog_word),
    .out_ready(prog_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ident_release;
    (st == ST_OUT && op == qfd_pkg::OP_IDENT && byte_cnt == qfd_pkg::ID_BYTES && sck_fall
     && !cs_s) |=> (dq_oe_n == 4'hF && st == ST_SKIP);
  endproperty
  a_ident_release: assert property (p_ident_release) else $error("ident not released");

  property p_busy_ident;
    (st == ST_CMD && sck_rise && !cs_s && cnt == 4'h1 && busy && code == qfd_pkg::CODE_IDENT)
    |=> (st == ST_SKIP && op == qfd_pkg::OP_NONE);
  endproperty
  a_busy_ident: assert property (p_busy_ident) else $error("ident decoded while busy");

  property p_deselect;
    cs_s |=> (dq_oe_n == 4'hF && st == ST_CMD && cnt == 4'h0);
  endproperty
  a_deselect: assert property (p_deselect) else $error("no standby on deselect");

  property p_out_on_fall;
    (!sck_fall && !cs_s) |=> $stable(dq_o);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("data moved off falling edge");

  property p_write_enable_cmd;
    (cs_rise && op == qfd_pkg::OP_WR_ENABLE) |=> write_enable_latch ##1 write_enable_latch;
  endproperty
  a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("latch not set");

  property p_write_disable_cmd;
    (cs_rise && op == qfd_pkg::OP_WR_DISABLE) |=> !write_enable_latch;
  endproperty
  a_write_disable_cmd: assert property (p_write_disable_cmd) else $error("latch not cleared");

  property p_write_needs_wel;
    (st == ST_IN || (st == ST_ADDR && op == qfd_pkg::OP_ERASE)) |-> write_enable_latch;
  endproperty
  a_write_needs_wel: assert property (p_write_needs_wel) else $error("write without latch");

  property p_otp_dummy;
    (st == ST_DUMMY && next_st == ST_OUT && op == qfd_pkg::OP_OTP_RD) |-> cnt == 4'h7;
  endproperty
  a_otp_dummy: assert property (p_otp_dummy) else $error("otp dummy not eight");

  property p_otp_limit;
    (push && op == qfd_pkg::OP_OTP_PR) |-> byte_cnt < qfd_pkg::OTP_BYTES;
  endproperty
  a_otp_limit: assert property (p_otp_limit) else $error("otp byte past 64");

  property p_erase;
    (cs_rise && op == qfd_pkg::OP_ERASE && addr_done && in_boot)
    |=> (erase_req && !write_enable_latch) ##1 !erase_req;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not issued");

  c_ident: cover property (st == ST_OUT && op == qfd_pkg::OP_IDENT && byte_cnt == 7'h03);
  c_read: cover property (st == ST_OUT && op == qfd_pkg::OP_READ && rd_req);
  c_prog: cover property (push && op == qfd_pkg::OP_PROG);
  c_erase: cover property (erase_req);
endmodule

/* File: verif/qfd_host.sv */
// host side quad spi controller model driving the serial pins
`timescale 1ns/1ps
module qfd_host (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic [3:0] dq_line,
  input wire logic [3:0] dev_dq,
  input wire logic [3:0] dev_oe_n
);
  logic drive;
  logic [3:0] host_dq;
  logic [3:0] last = 4'h0;
  // released line shows the inverse of the last driven value, never a stale copy
  assign dq_line = drive ? host_dq : ((dev_oe_n == 4'h0) ? dev_dq : ~last);
  always @(posedge clk) begin
    if (drive || dev_oe_n == 4'h0) last <= dq_line;
  end
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    drive = 1'b0;
    host_dq = 4'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one serial clock of 16 clk: fall, sample just before rise, rise
  task automatic cycle(input logic en, input logic [3:0] nib, output logic [3:0] seen);
    sclk = 1'b0;
    drive = en;
    host_dq = nib;
    tick(8);
    seen = dq_line;
    sclk = 1'b1;
    tick(8);
  endtask
  task automatic send8(input logic [7:0] b);
    logic [3:0] s;
    cycle(1'b1, b[7:4], s);
    cycle(1'b1, b[3:0], s);
  endtask
  task automatic frame(input logic [7:0] code, input logic use_addr, input logic [23:0] a);
    logic [3:0] s;
    tick(1);
    cs_n = 1'b0;
    tick(8);
    send8(code);
    if (use_addr) begin
      for (int i = 0; i < 6; i++) cycle(1'b1, a[23-4*i -: 4], s);
    end
  endtask
  task automatic abort();
    drive = 1'b0;
    cs_n = 1'b1;
    tick(6);
  endtask
  task automatic deselect();
    tick(8);
    abort();
    tick(10);
  endtask
endmodule

/* File: verif/test_quad_io_flash_command_decoder.sv */
// self-checking testbench for the quad flash command decoder
`timescale 1ns/1ps
module test_quad_io_flash_command_decoder;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic busy = 1'b0;
  logic [3:0] dummy_cycles = 4'hA;
  logic prog_ready = 1'b1;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic req_d = 1'b0;
  logic cs_n, sclk, write_enable_latch, rd_req, rd_otp, prog_valid, prog_overrun, erase_req;
  logic [3:0] dq_i, dq_o, dq_oe_n;
  logic [23:0] rd_addr;
  logic [11:0] erase_subsector, last_sub;
  qfd_pkg::qfd_prog_type prog_word;
  qfd_pkg::qfd_prog_type got[$];
  int n_errors = 0;
  int num_checks = 0;
  int n_erase = 0;
  logic [3:0] s;
  logic [23:0] ident;
  always #5 clk = ~clk;
  qfd_host qfd_host_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .dq_line(dq_i),
    .dev_dq(dq_o), .dev_oe_n(dq_oe_n));
  qfd_decoder qfd_decoder_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .busy(busy), .dummy_cycles(dummy_cycles),
    .write_enable_latch(write_enable_latch), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_otp(rd_otp), .rd_data(rd_data), .rd_valid(rd_valid), .prog_valid(prog_valid),
    .prog_word(prog_word), .prog_ready(prog_ready), .prog_overrun(prog_overrun),
    .erase_req(erase_req), .erase_subsector(erase_subsector));
  //////////////////////////////////////////////////////////////////////////////
  // array stand-in: answers two clk after the request, data derived from address
  always @(posedge clk) begin
    req_d <= rd_req;
    rd_valid <= req_d;
    rd_data <= rd_addr[7:0] ^ 8'hA5;
    if (prog_valid && prog_ready) got.push_back(prog_word);
    if (erase_req) begin
      n_erase++;
      last_sub = erase_subsector;
    end
  end
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic rd_nib(input logic [3:0] exp, input string what);
    qfd_host_inst.cycle(1'b0, 4'h0, s);
    check(what, {29'h0, s}, {29'h0, exp});
  endtask
  task automatic write_enable_cmd();
    qfd_host_inst.frame(qfd_pkg::CODE_WR_ENABLE, 1'b0, 24'h0);
    qfd_host_inst.deselect();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_ident();
    ident = {qfd_pkg::ID_MAKER, qfd_pkg::ID_PART};
    qfd_host_inst.frame(qfd_pkg::CODE_IDENT, 1'b0, 24'h0);
    for (int i = 0; i < 6; i++) rd_nib(ident[23-4*i -: 4], "ident nibble");
    qfd_host_inst.cycle(1'b0, 4'h0, s);
    check("oe after ident", dq_oe_n, 4'hF);
    qfd_host_inst.deselect();
    qfd_host_inst.frame(qfd_pkg::CODE_IDENT, 1'b0, 24'h0);
    rd_nib(ident[23:20], "ident first");
    qfd_host_inst.abort();
    check("oe after abort", dq_oe_n, 4'hF);
    qfd_host_inst.deselect();
  endtask
  task automatic t_read(input logic [7:0] code, input logic [3:0] dum, input logic otp);
    logic [23:0] a;
    a = otp ? 24'h000005 : 24'h3C2A10;
    dummy_cycles = dum;
    qfd_host_inst.frame(code, 1'b1, a);
    repeat (otp ? 8 : int'(dum)) qfd_host_inst.cycle(1'b0, 4'h0, s);
    for (int b = 0; b < 2; b++) begin
      rd_nib((a[7:0] + 8'(b)) >> 4 ^ 4'hA, "read high nibble");
      rd_nib((a[3:0] + 4'(b)) ^ 4'h5, "read low nibble");
    end
    check("otp select", rd_otp, otp);
    qfd_host_inst.deselect();
  endtask
  task automatic t_latch();
    write_enable_cmd();
    check("latch set", write_enable_latch, 1'b1);
    qfd_host_inst.frame(qfd_pkg::CODE_WR_DISABLE, 1'b0, 24'h0);
    qfd_host_inst.deselect();
    check("latch clear", write_enable_latch, 1'b0);
  endtask
  task automatic t_prog(input logic [7:0] code, input logic otp, input logic [23:0] a,
                        input logic [23:0] a2, input logic with_wel);
    got.delete();
    if (with_wel) write_enable_cmd();
    qfd_host_inst.frame(code, 1'b1, a);
    qfd_host_inst.send8(8'h3C);
    qfd_host_inst.send8(8'hC3);
    qfd_host_inst.deselect();
    check("latch after program", write_enable_latch, 1'b0);
    check("no overrun", prog_overrun, 1'b0);
    check("word count", 33'(got.size()), with_wel ? 33'h2 : 33'h0);
    if (with_wel) begin
      check("word 0", got[0], {otp, a, 8'h3C});
      check("word 1", got[1], {otp, a2, 8'hC3});
    end
  endtask
  task automatic t_erase(input logic [23:0] a, input int exp_n);
    n_erase = 0;
    write_enable_cmd();
    qfd_host_inst.frame(qfd_pkg::CODE_ERASE, 1'b1, a);
    qfd_host_inst.deselect();
    check("erase count", 33'(n_erase), 33'(exp_n));
    if (exp_n == 1) check("erase subsector", last_sub, a[23:12]);
    check("latch after erase", write_enable_latch, 1'b0);
  endtask
  task automatic t_busy();
    busy = 1'b1;
    qfd_host_inst.frame(qfd_pkg::CODE_IDENT, 1'b0, 24'h0);
    qfd_host_inst.cycle(1'b0, 4'h0, s);
    check("ident while busy", dq_oe_n, 4'hF);
    qfd_host_inst.deselect();
    qfd_host_inst.frame(qfd_pkg::CODE_RDSR, 1'b0, 24'h0);
    rd_nib(4'h0, "status high");
    rd_nib(4'h1, "status low");
    qfd_host_inst.deselect();
    busy = 1'b0;
  endtask
  task automatic t_overrun();
    prog_ready = 1'b0;
    got.delete();
    write_enable_cmd();
    qfd_host_inst.frame(qfd_pkg::CODE_PROG_A, 1'b1, 24'h000100);
    for (int i = 0; i < 8; i++) qfd_host_inst.send8(8'(i));
    qfd_host_inst.deselect();
    check("overrun", prog_overrun, 1'b1);
    prog_ready = 1'b1;
    qfd_host_inst.tick(12);
    check("first kept word", got[0], {1'b0, 24'h000100, 8'h00});
    check("kept words", 33'(got.size()), 33'h5);
    check("drained", prog_valid, 1'b0);
  endtask
  task automatic t_otp_limit();
    got.delete();
    write_enable_cmd();
    qfd_host_inst.frame(qfd_pkg::CODE_OTP_PR, 1'b1, 24'h000000);
    for (int i = 0; i < 66; i++) qfd_host_inst.send8(8'(i));
    qfd_host_inst.deselect();
    check("otp words kept", 33'(got.size()), 33'(qfd_pkg::OTP_BYTES));
    check("last otp word", got[63], {1'b1, 24'h00003F, 8'h3F});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    qfd_host_inst.tick(5);
    rst_n = 1'b1;
    check("oe at reset", dq_oe_n, qfd_pkg::OE_N_RESET);
    check("latch at reset", write_enable_latch, qfd_pkg::LATCH_RESET);
    qfd_host_inst.tick(3);
    t_ident();
    t_read(qfd_pkg::CODE_READ_A, 4'hA, 1'b0);
    t_read(qfd_pkg::CODE_READ_B, 4'h4, 1'b0);
    t_read(qfd_pkg::CODE_READ_C, 4'hA, 1'b0);
    t_read(qfd_pkg::CODE_OTP_RD, 4'h4, 1'b1);
    dummy_cycles = 4'hA;
    t_latch();
    t_prog(qfd_pkg::CODE_PROG_A, 1'b0, 24'h0A00FF, 24'h0A0000, 1'b1);
    t_prog(qfd_pkg::CODE_PROG_B, 1'b0, 24'h0A0010, 24'h0A0011, 1'b1);
    t_prog(qfd_pkg::CODE_PROG_C, 1'b0, 24'h0A0020, 24'h0A0021, 1'b1);
    t_prog(qfd_pkg::CODE_PROG_A, 1'b0, 24'h0A0020, 24'h0A0021, 1'b0);
    t_prog(qfd_pkg::CODE_OTP_PR, 1'b1, 24'h00003F, 24'h000000, 1'b1);
    t_erase(24'h07F123, 1);
    t_erase(24'h080000, 0);
    t_busy();
    t_otp_limit();
    t_overrun();
    end_of_test();
  end
endmodule
